/* File: hw/pmlc_i2c_slave.sv */
// two-wire serial register port of the power monitor
`timescale 1ns/100ps
`default_nettype none

module pmlc_i2c_slave
	import pmlc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h40
) (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOeN,
	output logic             wrStb,
	output logic [7:0]       regAddr,
	output logic [15:0]      wrData,
	output logic             rdStb,
	input  wire logic [15:0] rdData
);

	typedef enum logic [2:0] {S_IDLE, S_RX, S_RXACK, S_ACK, S_TX, S_MACK} pmlc_i2c_state_type;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic sclMeta_q, sclSync_q, sclPrev_q, sdaMeta_q, sdaSync_q, sdaPrev_q;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sclMeta_q <= 1'b1;
			sclSync_q <= 1'b1;
			sclPrev_q <= 1'b1;
			sdaMeta_q <= 1'b1;
			sdaSync_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclMeta_q <= sclIn;
			sclSync_q <= sclMeta_q;
			sclPrev_q <= sclSync_q;
			sdaMeta_q <= sdaIn;
			sdaSync_q <= sdaMeta_q;
			sdaPrev_q <= sdaSync_q;
		end
	end

	logic sclRise, sclFall, startCond, stopCond;
	assign sclRise   = sclSync_q & ~sclPrev_q;
	assign sclFall   = ~sclSync_q & sclPrev_q;
	assign startCond = sclSync_q & sclPrev_q & sdaPrev_q & ~sdaSync_q;
	assign stopCond  = sclSync_q & sclPrev_q & ~sdaPrev_q & sdaSync_q;

	// ************************************************************
	// byte engine
	// ************************************************************
	pmlc_i2c_state_type st_q, st_d;
	logic [2:0]  cnt_q, cnt_d;
	logic [1:0]  phase_q, phase_d;
	logic [7:0]  sh_q, sh_d, ptr_q, ptr_d, hi_q, hi_d;
	logic [15:0] tx_q, tx_d, wdat_q, wdat_d;
	logic        rw_q, rw_d, lo_q, lo_d, oeN_q, oeN_d, wr_q, wr_d, rd_q, rd_d;

	always_comb begin
		logic [15:0] word;
		word    = tx_q;
		st_d    = st_q;
		cnt_d   = cnt_q;
		phase_d = phase_q;
		sh_d    = sh_q;
		ptr_d   = ptr_q;
		hi_d    = hi_q;
		tx_d    = tx_q;
		wdat_d  = wdat_q;
		rw_d    = rw_q;
		lo_d    = lo_q;
		oeN_d   = oeN_q;
		wr_d    = 1'b0;
		rd_d    = 1'b0;
		if (startCond) begin
			st_d    = S_RX;
			cnt_d   = 3'd0;
			phase_d = 2'd0;
			oeN_d   = 1'b1;
		end else if (stopCond) begin
			st_d  = S_IDLE;
			oeN_d = 1'b1;
		end else begin
			case (st_q)
				S_RX: begin
					if (sclRise) begin
						sh_d  = {sh_q[6:0], sdaSync_q};
						cnt_d = cnt_q + 3'd1;
						if (cnt_q == 3'd7) st_d = S_RXACK;
					end
				end
				S_RXACK: begin
					if (sclFall) begin
						oeN_d = 1'b0;
						st_d  = S_ACK;
						case (phase_q)
							2'd0: begin
								if (sh_q[7:1] != DEV_ADDR) begin
									oeN_d = 1'b1;
									st_d  = S_IDLE;
								end else begin
									rw_d = sh_q[0];
									if (sh_q[0]) begin
										tx_d = rdData;
										rd_d = 1'b1;
										lo_d = 1'b0;
									end
								end
							end
							2'd1: ptr_d = sh_q;
							2'd2: hi_d = sh_q;
							default: begin
								wdat_d = {hi_q, sh_q};
								wr_d   = 1'b1;
							end
						endcase
					end
				end
				S_ACK: begin
					if (sclFall) begin
						cnt_d = 3'd0;
						if (phase_q == 2'd0 && rw_q) begin
							st_d  = S_TX;
							oeN_d = tx_q[15];
							tx_d  = {tx_q[14:0], 1'b0};
						end else begin
							st_d    = S_RX;
							oeN_d   = 1'b1;
							phase_d = (phase_q == 2'd3) ? 2'd2 : phase_q + 2'd1;
						end
					end
				end
				S_TX: begin
					if (sclRise) begin
						cnt_d = cnt_q + 3'd1;
					end else if (sclFall) begin
						if (cnt_q == 3'd0) begin
							oeN_d = 1'b1;
							st_d  = S_MACK;
						end else begin
							oeN_d = tx_q[15];
							tx_d  = {tx_q[14:0], 1'b0};
						end
					end
				end
				S_MACK: begin
					if (sclRise) begin
						if (sdaSync_q) st_d = S_IDLE;
						else cnt_d = 3'd1;
					end else if (sclFall && cnt_q == 3'd1) begin
						word  = lo_q ? rdData : tx_q;
						rd_d  = lo_q;
						oeN_d = word[15];
						tx_d  = {word[14:0], 1'b0};
						lo_d  = ~lo_q;
						cnt_d = 3'd0;
						st_d  = S_TX;
					end
				end
				default: st_d = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q    <= S_IDLE;
			cnt_q   <= 3'd0;
			phase_q <= 2'd0;
			sh_q    <= 8'h00;
			ptr_q   <= 8'h00;
			hi_q    <= 8'h00;
			tx_q    <= 16'h0000;
			wdat_q  <= 16'h0000;
			rw_q    <= 1'b0;
			lo_q    <= 1'b0;
			oeN_q   <= 1'b1;
			wr_q    <= 1'b0;
			rd_q    <= 1'b0;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			phase_q <= phase_d;
			sh_q    <= sh_d;
			ptr_q   <= ptr_d;
			hi_q    <= hi_d;
			tx_q    <= tx_d;
			wdat_q  <= wdat_d;
			rw_q    <= rw_d;
			lo_q    <= lo_d;
			oeN_q   <= oeN_d;
			wr_q    <= wr_d;
			rd_q    <= rd_d;
		end
	end

	assign sdaOut  = 1'b0;
	assign sdaOeN  = oeN_q;
	assign wrStb   = wr_q;
	assign rdStb   = rd_q;
	assign regAddr = ptr_q;
	assign wrData  = wdat_q;

endmodule

`default_nettype wire

/* File: hw/pmlc_power_monitor.sv */
// limit comparison, result scaling and registers of the power monitor
//
// Behaviour
// - trim checksum error clears memory-ok bit
// - shunt over limit signed, resets 7FFF
// - negative over limit trips on zero shunt
// - shunt under limit signed, resets 8000
// - bus over limit 15 bits, top zero
// - bus under limit 15 bits, resets zero
// - temperature limit bits 15:4, compared directly
// - power limit step equals 256 power steps
// - read-only identity register, fixed contents
// - shunt result and thresholds share scaling
// - shunt signed, bus non-negative, 16 bits
// - die temperature 12-bit two's complement
// - current from shunt and calibration, zero cal
// - power is 24-bit unsigned result
// - conversions spaced at least 50 us
// - shunt over flag set when exceeded
// - latched flags hold until diagnostic read
`timescale 1ns/100ps
`default_nettype none

module pmlc_power_monitor
	import pmlc_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR      = 7'h40,
	parameter logic [15:0] IDENTITY_CODE = 16'h4D4F  // arbitrary value
) (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOeN,
	output logic             alertOut,
	output logic             alertOeN,
	input  wire logic        shuntValid,
	input  wire logic [15:0] shuntResult,
	input  wire logic        busValid,
	input  wire logic [15:0] busResult,
	input  wire logic        tempValid,
	input  wire logic [11:0] tempResult,
	input  wire logic        trimChecksumErr
);

	// ************************************************************
	// register port
	// ************************************************************
	logic        wrStb, rdStb;
	logic [7:0]  regAddr;
	logic [15:0] wrData, rdData;

	pmlc_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_port (
		.clk_sys (clk_sys),
		.reset   (reset),
		.sclIn   (sclIn),
		.sdaIn   (sdaIn),
		.sdaOut  (sdaOut),
		.sdaOeN  (sdaOeN),
		.wrStb   (wrStb),
		.regAddr (regAddr),
		.wrData  (wrData),
		.rdStb   (rdStb),
		.rdData  (rdData)
	);

	function automatic logic hitWrite(input logic stb, input logic [7:0] a, input logic [7:0] target);
		return stb && (a == target);
	endfunction

	// ************************************************************
	// configuration registers
	// ************************************************************
	logic [15:0] shuntOverThr_q, shuntOverThr_d, shuntUnderThr_q, shuntUnderThr_d, powerLimit_q, powerLimit_d;
	logic [14:0] busOverThr_q, busOverThr_d, busUnderThr_q, busUnderThr_d, shuntCal_q, shuntCal_d;
	logic [11:0] tempLimit_q, tempLimit_d;
	logic [3:0]  diagCtl_q, diagCtl_d;
	logic        latchMode;

	always_comb begin
		shuntOverThr_d  = shuntOverThr_q;
		shuntUnderThr_d = shuntUnderThr_q;
		busOverThr_d    = busOverThr_q;
		busUnderThr_d   = busUnderThr_q;
		tempLimit_d     = tempLimit_q;
		powerLimit_d    = powerLimit_q;
		shuntCal_d      = shuntCal_q;
		diagCtl_d       = diagCtl_q;
		if (hitWrite(wrStb, regAddr, ADDR_SHUNT_OVER)) shuntOverThr_d = wrData;
		if (hitWrite(wrStb, regAddr, ADDR_SHUNT_UNDER)) shuntUnderThr_d = wrData;
		if (hitWrite(wrStb, regAddr, ADDR_BUS_OVER)) busOverThr_d = wrData[14:0];
		if (hitWrite(wrStb, regAddr, ADDR_BUS_UNDER)) busUnderThr_d = wrData[14:0];
		if (hitWrite(wrStb, regAddr, ADDR_TEMP_LIMIT)) tempLimit_d = wrData[15:4];
		if (hitWrite(wrStb, regAddr, ADDR_POWER_LIMIT)) powerLimit_d = wrData;
		if (hitWrite(wrStb, regAddr, ADDR_SHUNT_CAL)) shuntCal_d = wrData[14:0];
		if (hitWrite(wrStb, regAddr, ADDR_DIAG)) diagCtl_d = wrData[15:DIAG_CTL_LSB];
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			shuntOverThr_q  <= SHUNT_OVER_RST;
			shuntUnderThr_q <= SHUNT_UNDER_RST;
			busOverThr_q    <= BUS_OVER_RST;
			busUnderThr_q   <= BUS_UNDER_RST;
			tempLimit_q     <= TEMP_LIMIT_RST;
			powerLimit_q    <= POWER_LIMIT_RST;
			shuntCal_q      <= SHUNT_CAL_RST;
			diagCtl_q       <= DIAG_CTL_RST;
		end else begin
			shuntOverThr_q  <= shuntOverThr_d;
			shuntUnderThr_q <= shuntUnderThr_d;
			busOverThr_q    <= busOverThr_d;
			busUnderThr_q   <= busUnderThr_d;
			tempLimit_q     <= tempLimit_d;
			powerLimit_q    <= powerLimit_d;
			shuntCal_q      <= shuntCal_d;
			diagCtl_q       <= diagCtl_d;
		end
	end

	assign latchMode = diagCtl_q[DIAG_LATCH - DIAG_CTL_LSB];

	// ************************************************************
	// conversion spacing and result registers
	// ************************************************************
	logic [10:0]        gap_q, gap_d;
	logic               gapOk, shuntAcc, busAcc, tempAcc, anyAcc;
	logic [15:0]        shuntRes_q, shuntRes_d, busRes_q, busRes_d, current_q, current_d, curMag;
	logic [11:0]        tempRes_q, tempRes_d;
	logic [23:0]        power_q, power_d;
	logic               powerPend_q, powerPend_d, mathOf_q, mathOf_d, trimOk_q, trimOk_d;
	logic signed [31:0] curProd, curShift;
	logic [31:0]        powProd, powShift;
	logic               curOvf, powOvf;

	// results closer than the shortest conversion are dropped
	assign gapOk    = gap_q >= MIN_CONV_CYCLES;
	assign shuntAcc = shuntValid & gapOk;
	assign busAcc   = busValid & gapOk;
	assign tempAcc  = tempValid & gapOk;
	assign anyAcc   = shuntAcc | busAcc | tempAcc;

	// current scaled from shunt result and calibration
	assign curProd  = $signed(shuntResult) * $signed({1'b0, shuntCal_q});
	assign curShift = curProd >>> CURRENT_SHIFT;
	assign curOvf   = curShift[31:15] != {17{curShift[15]}};
	// power magnitude, saturated to 24 bits
	assign curMag   = current_q[15] ? 16'(-current_q) : current_q;
	assign powProd  = curMag * busRes_q;
	assign powShift = powProd >> POWER_SHIFT;
	assign powOvf   = |powShift[31:24];

	always_comb begin
		gap_d       = anyAcc ? 11'd1 : (gapOk ? gap_q : gap_q + 11'd1);
		shuntRes_d  = shuntRes_q;
		busRes_d    = busRes_q;
		tempRes_d   = tempRes_q;
		current_d   = current_q;
		power_d     = power_q;
		mathOf_d    = mathOf_q;
		powerPend_d = shuntAcc | busAcc;
		// checksum error clears the memory-ok bit until reset
		trimOk_d    = trimOk_q & ~trimChecksumErr;
		// signed shunt and non-negative bus words
		if (shuntAcc) begin
			shuntRes_d = shuntResult;
			mathOf_d   = 1'b0;
			// zero calibration gives a zero product
			current_d  = curOvf ? (curShift[31] ? 16'h8000 : 16'h7FFF) : curShift[15:0];
			if (curOvf) mathOf_d = 1'b1;
		end
		if (busAcc) busRes_d = busResult;
		if (tempAcc) tempRes_d = tempResult;
		// power follows one cycle after its inputs
		if (powerPend_q) begin
			power_d = powOvf ? 24'hFF_FFFF : powShift[23:0];
			if (powOvf) mathOf_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			gap_q       <= MIN_CONV_CYCLES;
			shuntRes_q  <= 16'h0000;
			busRes_q    <= 16'h0000;
			tempRes_q   <= 12'h000;
			current_q   <= 16'h0000;
			power_q     <= 24'h00_0000;
			powerPend_q <= 1'b0;
			mathOf_q    <= 1'b0;
			trimOk_q    <= 1'b1;
		end else begin
			gap_q       <= gap_d;
			shuntRes_q  <= shuntRes_d;
			busRes_q    <= busRes_d;
			tempRes_q   <= tempRes_d;
			current_q   <= current_d;
			power_q     <= power_d;
			powerPend_q <= powerPend_d;
			mathOf_q    <= mathOf_d;
			trimOk_q    <= trimOk_d;
		end
	end

	// ************************************************************
	// limit flags
	// ************************************************************
	logic [7:1] flags_q, flags_d, trip, evt;
	logic       rdDiag;

	assign rdDiag = hitWrite(rdStb, regAddr, ADDR_DIAG);

	// compare on the result that is being loaded this cycle
	always_comb begin
		trip = '0;
		evt  = '0;
		trip[FLAG_TEMP_OVER]   = $signed(tempResult) > $signed(tempLimit_q);
		// signed compare, zero exceeds a negative limit
		trip[FLAG_SHUNT_OVER]  = $signed(shuntResult) > $signed(shuntOverThr_q);
		trip[FLAG_SHUNT_UNDER] = $signed(shuntResult) < $signed(shuntUnderThr_q);
		trip[FLAG_BUS_OVER]    = busResult > {1'b0, busOverThr_q};
		trip[FLAG_BUS_UNDER]   = busResult < {1'b0, busUnderThr_q};
		trip[FLAG_POWER_OVER]  = power_d[23:8] > powerLimit_q;
		trip[FLAG_CONV_READY]  = 1'b1;
		evt[FLAG_TEMP_OVER]    = tempAcc;
		evt[FLAG_SHUNT_OVER]   = shuntAcc;
		evt[FLAG_SHUNT_UNDER]  = shuntAcc;
		evt[FLAG_BUS_OVER]     = busAcc;
		evt[FLAG_BUS_UNDER]    = busAcc;
		evt[FLAG_POWER_OVER]   = powerPend_q;
		evt[FLAG_CONV_READY]   = anyAcc;
	end

	function automatic logic flagNext(input logic old, input logic clr, input logic ev,
		input logic tr, input logic lat);
		logic v;
		v = clr ? 1'b0 : old;
		if (ev) v = lat ? (v | tr) : tr;
		return v;
	endfunction

	genvar gi;
	generate
		for (gi = 1; gi <= 7; gi++) begin : g_flag
			// latched flags hold until a diagnostic read, a new event wins
			assign flags_d[gi] = flagNext(flags_q[gi], rdDiag & (latchMode | (gi == FLAG_CONV_READY)),
				evt[gi], trip[gi], latchMode | (gi == FLAG_CONV_READY));
		end
	endgenerate

	// ************************************************************
	// alert pin
	// ************************************************************
	logic alertAct, alertOeN_q, alertOeN_d, alertOut_q;
	assign alertAct   = (|flags_q[7:2]) | (diagCtl_q[DIAG_CNVR - DIAG_CTL_LSB] & flags_q[FLAG_CONV_READY]);
	assign alertOeN_d = ~(alertAct ^ diagCtl_q[DIAG_APOL - DIAG_CTL_LSB]);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flags_q    <= '0;
			alertOeN_q <= 1'b1;
			alertOut_q <= 1'b0;
		end else begin
			flags_q    <= flags_d;
			alertOeN_q <= alertOeN_d;
			alertOut_q <= 1'b0;
		end
	end

	assign alertOut = alertOut_q;
	assign alertOeN = alertOeN_q;

	// ************************************************************
	// read data
	// ************************************************************
	always_comb begin
		case (regAddr)
			ADDR_SHUNT_CAL:    rdData = {1'b0, shuntCal_q};
			ADDR_SHUNT_RESULT: rdData = shuntRes_q;
			ADDR_BUS_RESULT:   rdData = busRes_q;
			ADDR_TEMP_RESULT:  rdData = {tempRes_q, 4'h0};
			ADDR_CURRENT:      rdData = current_q;
			ADDR_POWER:        rdData = power_q[23:8];
			ADDR_DIAG:         rdData = {diagCtl_q, 2'b00, mathOf_q, 1'b0, flags_q, trimOk_q};
			// thresholds read back raw, same scale as results
			ADDR_SHUNT_OVER:   rdData = shuntOverThr_q;
			ADDR_SHUNT_UNDER:  rdData = shuntUnderThr_q;
			ADDR_BUS_OVER:     rdData = {1'b0, busOverThr_q};
			ADDR_BUS_UNDER:    rdData = {1'b0, busUnderThr_q};
			ADDR_TEMP_LIMIT:   rdData = {tempLimit_q, 4'h0};
			ADDR_POWER_LIMIT:  rdData = powerLimit_q;
			ADDR_IDENTITY:     rdData = IDENTITY_CODE;
			default:           rdData = 16'h0000;
		endcase
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence sShuntOnly;
		shuntAcc && !busAcc;
	endsequence
	sequence sPowerDone;
		powerPend_q ##1 (power_q == ($past(powOvf) ? 24'hFF_FFFF : $past(powShift[23:0])));
	endsequence

	a_trim_sticky: assert property ((trimChecksumErr || !trimOk_q) |=> !trimOk_q)
		else $error("memory-ok bit not cleared");
	a_shunt_over: assert property (shuntAcc && !latchMode |=> flags_q[FLAG_SHUNT_OVER] ==
		($signed($past(shuntResult)) > $signed($past(shuntOverThr_q))))
		else $error("shunt over flag wrong");
	a_zero_negthr: assert property (shuntAcc && shuntResult == 16'h0000 && shuntOverThr_q[15]
		|=> flags_q[FLAG_SHUNT_OVER])
		else $error("zero shunt did not trip negative limit");
	a_shunt_under: assert property (shuntAcc && !latchMode |=> flags_q[FLAG_SHUNT_UNDER] ==
		($signed($past(shuntResult)) < $signed($past(shuntUnderThr_q))))
		else $error("shunt under flag wrong");
	a_bus_over: assert property (busAcc && !latchMode |=> flags_q[FLAG_BUS_OVER] ==
		($past(busResult) > {1'b0, $past(busOverThr_q)}))
		else $error("bus over flag wrong");
	a_bus_under: assert property (busAcc && !latchMode |=> flags_q[FLAG_BUS_UNDER] ==
		($past(busResult) < {1'b0, $past(busUnderThr_q)}))
		else $error("bus under flag wrong");
	a_temp_over: assert property (tempAcc && !latchMode |=> flags_q[FLAG_TEMP_OVER] ==
		($signed($past(tempResult)) > $signed($past(tempLimit_q))))
		else $error("temperature flag wrong");
	a_power_limit: assert property (powerPend_q && !latchMode |=> flags_q[FLAG_POWER_OVER] ==
		(power_q[23:8] > $past(powerLimit_q)))
		else $error("power flag wrong");
	a_ident_read: assert property (regAddr == ADDR_IDENTITY |-> rdData == IDENTITY_CODE)
		else $error("identity word wrong");
	a_cur_zero: assert property (shuntAcc && shuntCal_q == 15'h0000 |=> current_q == 16'h0000)
		else $error("current not zero with zero calibration");
	a_power_follow: assert property (sShuntOnly |=> sPowerDone)
		else $error("power not updated after shunt result");
	a_conv_gap: assert property ($changed(shuntRes_q) |-> $past(gap_q) >= MIN_CONV_CYCLES)
		else $error("result taken too soon");
	a_latch_hold: assert property (latchMode && flags_q[FLAG_SHUNT_OVER] && !rdDiag
		|=> flags_q[FLAG_SHUNT_OVER])
		else $error("latched flag dropped without read");
	a_flag_timing: assert property (shuntAcc && !latchMode && !shuntRes_q[15]
		##1 $changed(shuntRes_q) |-> flags_q[FLAG_SHUNT_OVER] == ($signed(shuntRes_q) > $signed(shuntOverThr_q))
		|| $changed(shuntOverThr_q))
		else $error("flag not updated with result");

endmodule

`default_nettype wire

/* File: pkg/pmlc_pkg.sv */
// shared constants of the power monitor limit compare block
`default_nettype none

package pmlc_pkg;

	// ************************************************************
	// register pointer addresses
	// ************************************************************
	localparam logic [7:0]  ADDR_SHUNT_CAL    = 8'h02;
	localparam logic [7:0]  ADDR_SHUNT_RESULT = 8'h04;
	localparam logic [7:0]  ADDR_BUS_RESULT   = 8'h05;
	localparam logic [7:0]  ADDR_TEMP_RESULT  = 8'h06;
	localparam logic [7:0]  ADDR_CURRENT      = 8'h07;
	localparam logic [7:0]  ADDR_POWER        = 8'h08;
	localparam logic [7:0]  ADDR_DIAG         = 8'h0B;
	localparam logic [7:0]  ADDR_SHUNT_OVER   = 8'h0C;
	localparam logic [7:0]  ADDR_SHUNT_UNDER  = 8'h0D;
	localparam logic [7:0]  ADDR_BUS_OVER     = 8'h0E;
	localparam logic [7:0]  ADDR_BUS_UNDER    = 8'h0F;
	localparam logic [7:0]  ADDR_TEMP_LIMIT   = 8'h10;
	localparam logic [7:0]  ADDR_POWER_LIMIT  = 8'h11;
	localparam logic [7:0]  ADDR_IDENTITY     = 8'h3E;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [15:0] SHUNT_OVER_RST    = 16'h7FFF;
	localparam logic [15:0] SHUNT_UNDER_RST   = 16'h8000;
	localparam logic [14:0] BUS_OVER_RST      = 15'h7FFF;
	localparam logic [14:0] BUS_UNDER_RST     = 15'h0000;
	localparam logic [11:0] TEMP_LIMIT_RST    = 12'h7FF;
	localparam logic [15:0] POWER_LIMIT_RST   = 16'hFFFF;
	localparam logic [14:0] SHUNT_CAL_RST     = 15'h1000;
	localparam logic [3:0]  DIAG_CTL_RST      = 4'h0;

	// ************************************************************
	// diagnostic flag register field positions
	// ************************************************************
	localparam int          DIAG_LATCH        = 15;
	localparam int          DIAG_CNVR         = 14;
	localparam int          DIAG_APOL         = 12;
	localparam int          DIAG_CTL_LSB      = 12;
	localparam int          FLAG_TEMP_OVER    = 7;
	localparam int          FLAG_SHUNT_OVER   = 6;
	localparam int          FLAG_SHUNT_UNDER  = 5;
	localparam int          FLAG_BUS_OVER     = 4;
	localparam int          FLAG_BUS_UNDER    = 3;
	localparam int          FLAG_POWER_OVER   = 2;
	localparam int          FLAG_CONV_READY   = 1;

	// ************************************************************
	// arithmetic scaling and timing
	// ************************************************************
	localparam int          CURRENT_SHIFT     = 11;
	localparam int          POWER_SHIFT       = 6;
	localparam int          CLK_PERIOD_NS     = 40;
	localparam int          MIN_CONV_TIME_NS  = 50000;
	localparam logic [10:0] MIN_CONV_CYCLES   =
		11'((MIN_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

`default_nettype wire

/* File: tb/pmlc_i2c_host.sv */
// serial host model for the register port
`timescale 1ns/100ps
`default_nettype none
module pmlc_i2c_host #(
	parameter logic [6:0] DEV_ADDR = 7'h40
) (
	input  wire logic clk,
	output logic      scl,
	output logic      sdaLow,
	input  wire logic sda
);
	logic [7:0] rxQ;
	// ********
	// bit, byte and frame tasks
	// ********
	task automatic bitx(input logic b);
		repeat (3) @(posedge clk);
		#1 sdaLow = !b;
		repeat (7) @(posedge clk);
		#1 scl = 1'b1;
		repeat (10) @(posedge clk);
		#1 rxQ = {rxQ[6:0], sda};
		scl = 1'b0;
	endtask
	task automatic byt(input logic [7:0] d, input logic m, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) bitx(d[i]);
		q = rxQ;
		bitx(m);
	endtask
	// start when s is high, stop otherwise
	task automatic frame(input logic s);
		repeat (3) @(posedge clk);
		#1 sdaLow = !s;
		repeat (7) @(posedge clk);
		#1 scl = 1'b1;
		repeat (10) @(posedge clk);
		#1 sdaLow = s;
		repeat (10) @(posedge clk);
		#1 scl = !s;
	endtask
	task automatic xfer(input logic rw, input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
		logic [7:0] q;
		frame(1'b1);
		byt({DEV_ADDR, 1'b0}, 1'b1, q);
		byt(a, 1'b1, q);
		if (rw) begin
			frame(1'b1);
			byt({DEV_ADDR, 1'b1}, 1'b1, q);
		end
		byt(rw ? 8'hFF : d[15:8], !rw, r[15:8]);
		byt(rw ? 8'hFF : d[7:0], 1'b1, r[7:0]);
		frame(1'b0);
	endtask
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench of the power monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin nErrors++; $display("Error %0t %h %h", $time, a, b); end end
module tb;
	localparam logic [7:0]  ADR [9] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h02, 8'h3E, 8'h0B};
	localparam logic [7:0]  RA [6]  = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0B};
	localparam logic [15:0] ID      = 16'h1A2B; // arbitrary value
	localparam logic [15:0] MSK [8] = '{16'hFFFF, 16'hFFFF, 16'h7FFF, 16'h7FFF, 16'hFFF0, 16'hFFFF, 16'h7FFF, 0};
	localparam logic [15:0] RST [9] = '{16'h7FFF, 16'h8000, 16'h7FFF, 0, 16'h7FF0, 16'hFFFF, 16'h1000, ID, 16'h0001};
	logic        clk_sys, reset, scl, sdaLow, sdaOeN, sdaOut, alertOeN, alertOut, trimChecksumErr, ov;
	logic        shuntValid, busValid, tempValid;
	logic [15:0] shuntResult, busResult, q, lim [8];
	logic [11:0] tempResult;
	int          nErrors, totalChecks, cyc, seed = 71957;
	wire logic   sda = !sdaLow && (sdaOeN || sdaOut);
	pmlc_power_monitor #(.IDENTITY_CODE(ID)) uut (.clk_sys(clk_sys), .reset(reset), .sclIn(scl), .sdaIn(sda),
		.sdaOut(sdaOut), .sdaOeN(sdaOeN), .alertOut(alertOut), .alertOeN(alertOeN), .shuntValid(shuntValid),
		.shuntResult(shuntResult), .busValid(busValid), .busResult(busResult), .tempValid(tempValid),
		.tempResult(tempResult), .trimChecksumErr(trimChecksumErr));
	pmlc_i2c_host host (.clk(clk_sys), .scl(scl), .sdaLow(sdaLow), .sda(sda));
	// ********
	// trial: program limits, feed results, read back
	// ********
	task automatic trial(input logic [15:0] s, input logic [15:0] b, input logic [11:0] t);
		longint      p, w;
		logic [15:0] ex [6];
		if ($signed(lim[0]) < $signed(lim[1])) {lim[0], lim[1]} = {lim[1], lim[0]};
		for (int k = 0; k < 8; k++) host.xfer(1'b0, ADR[k], lim[k], q);
		for (int k = 0; k < 8; k++) begin
			host.xfer(1'b1, ADR[k], 16'h0000, q);
			`CHK(q, k == 7 ? ID : lim[k] & MSK[k])
		end
		busResult = b;
		tempResult = t;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			#1 {shuntValid, busValid, tempValid} = 3'b111;
			shuntResult = k ? ~s : s;
			@(posedge clk_sys);
			#1 {shuntValid, busValid, tempValid} = 3'b000;
		end
		p = longint'($signed(s)) * longint'(lim[6] & 16'h7FFF);
		p = p >>> 11;
		ov = p > 32767 || p < -32768;
		p = p > 32767 ? 32767 : p < -32768 ? -32768 : p;
		w = ((p < 0 ? -p : p) * longint'(b)) >> 6;
		ex = '{s, b, {t, 4'h0}, p[15:0], w[23:8], {6'h00, ov, 1'b0, $signed(t) > $signed(lim[4][15:4]),
			$signed(s) > $signed(lim[0]), $signed(s) < $signed(lim[1]), b > lim[2][14:0], b < lim[3][14:0],
			w[23:8] > lim[5], 2'b11}};
		for (int k = 0; k < 6; k++) begin
			host.xfer(1'b1, RA[k], 16'h0000, q);
			`CHK(q, ex[k])
		end
		`CHK(alertOeN | alertOut, ~|ex[5][7:2])
	endtask
	task automatic closeOut;
		if (nErrors == 0 && totalChecks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 95000) begin
			nErrors++;
			closeOut;
		end
	end
	initial begin
		{clk_sys, shuntValid, busValid, tempValid, trimChecksumErr} = 5'h00;
		{shuntResult, busResult, tempResult} = 44'h0;
		reset = 1'b1;
		repeat (8) @(posedge clk_sys);
		#1 reset = 1'b0;
		repeat (4) @(posedge clk_sys);
		for (int k = 0; k < 9; k++) begin
			host.xfer(1'b1, ADR[k], 16'h0000, q);
			`CHK(q, RST[k])
		end
		lim = '{16'hFFF0, 16'h8000, 16'h7FFF, 0, 16'h7FF0, 16'hFFFF, 16'h1000, 0};
		trial(16'h0000, 16'h0000, 12'h7FF);
		for (int n = 0; n < 2; n++) begin
			foreach (lim[k]) lim[k] = 16'($random(seed));
			if (n == 1) lim[6] = 16'h0000;
			trial(16'($random(seed)), 16'($random(seed)) & 16'h7FFF, 12'($random(seed)));
		end
		// latched, inverted alert: bus over held until read
		host.xfer(1'b0, 8'h0B, 16'h9000, q);
		host.xfer(1'b0, 8'h0E, 16'h0000, q);
		for (int k = 1; k >= 0; k--) begin
			repeat (1300) @(posedge clk_sys);
			#1 {busValid, busResult} = {1'b1, 16'(k)};
			@(posedge clk_sys);
			#1 busValid = 1'b0;
		end
		repeat (4) @(posedge clk_sys);
		`CHK(alertOeN | alertOut, 1'b1)
		host.xfer(1'b1, 8'h0B, 16'h0000, q);
		`CHK(q[4], 1'b1)
		host.xfer(1'b1, 8'h0B, 16'h0000, q);
		`CHK(q, 16'h9001)
		`CHK(alertOeN | alertOut, 1'b0)
		@(posedge clk_sys);
		#1 trimChecksumErr = 1'b1;
		@(posedge clk_sys);
		#1 trimChecksumErr = 1'b0;
		host.xfer(1'b1, 8'h0B, 16'h0000, q);
		`CHK(q[0], 1'b0)
		closeOut;
	end
endmodule
`default_nettype wire
